// File: rtl/ct_unit.sv
/*
 * counter/timer, power-down select, multipurpose output selector and
 * interrupt status/mask of a single-channel serial controller.
 * assumes: channel status pulses come from logic on core_clk_i; the
 * oscillator clock and multipurpose input are asynchronous pins.
 */
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "ct_unit_regs.svh"

//Function
// - modes 000-011 counter with four clock sources
// - modes 100-111 timer with four clock sources
// - power-down select zero freezes oscillator functions
// - power-down drives oscillator input low, output high
// - rate generator sixteen-times clocks, fifty percent duty
// - code 000 gives request-to-send, auto clear options
// - code 001 gives counter/timer output
// - codes 010-101 give shift clocks
// - codes 110/111 give inverted ready statuses
// - masked status drives interrupt low; reads unmasked
// - reset clears interrupt status bits 7-2; bits 1,0 follow the channel
// - bit 7 sets on input change, command clears
// - bit 6 latches input level at read
// - bit 3 sets on break change, command clears
// - bit 2 receiver ready or fifo full
// - bits 1,0 mirror transmitter empty, ready
// - timer square wave, ready once per cycle
// - timer count change applies next half-period
// - counter counts down, ready at terminal count
// - counter writes apply at next start
// - start preloads and starts (counter only when idle); stop clears ready
// - commands clear change and break status
module ct_unit (
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_b_i,
    input  wire ct_unit_pkg::reg_req_t reg_req_i,
    output logic [7:0]                 reg_rdata_o,
    input  wire ct_unit_pkg::chan_in_t chan_i,
    input  wire logic                  multipurpose_input_pin_i,
    input  wire logic                  osc_clk_i,
    input  wire logic                  rate_generator_16x_i,
    output logic                       multipurpose_output_pin_o,
    output logic                       interrupt_request_n_o,
    output logic                       oscillator_input_o,
    output logic                       oscillator_input_oe_o,
    output logic                       oscillator_output_o,
    output logic                       osc_enable_o
);

    // rate generator 16x clock arrives from outside and is only buffered here
    logic [7:0]  auxiliary_control_q;
    logic [7:0]  interrupt_mask_q;
    logic [7:0]  count_upper_byte_q;
    logic [7:0]  count_lower_byte_q;
    logic [7:0]  mode_ctrl_q;
    logic [15:0] ct_value_q,  ct_value_d;
    logic [15:0] ct_start_q,  ct_start_d;
    logic        ct_wave_q,   ct_wave_d;
    logic        ct_half_q,   ct_half_d;
    logic        ct_term_q,   ct_term_d;
    ct_unit_pkg::ct_state_t ct_state_q, ct_state_d;
    logic [3:0]  mpi_div_q,   osc_div_q;
    logic        mpi_div_tick_q, osc_div_tick_q;
    logic [1:0]  mpi_sync_q,  osc_sync_q;
    logic        mpi_last_q,  osc_last_q;
    logic        mpi_chg_q,   brk_chg_q,   ct_ready_q,  rx_flag_q;
    logic        mpi_level_q;
    logic        rts_reg_q;
    logic        mpo_q,       intr_n_q;
    logic [7:0]  rdata_q;

    // decoding
    wire         wr_aux   = reg_req_i.wr && reg_req_i.addr == `AUX_CTRL_ADDR;
    wire         wr_mask  = reg_req_i.wr && reg_req_i.addr == `INT_MASK_ADDR;
    wire         wr_upper = reg_req_i.wr && reg_req_i.addr == `CNT_UPPER_ADDR;
    wire         wr_lower = reg_req_i.wr && reg_req_i.addr == `CNT_LOWER_ADDR;
    wire         wr_mode  = reg_req_i.wr && reg_req_i.addr == `MODE_CTRL_ADDR;
    wire         wr_cmd   = reg_req_i.wr && reg_req_i.addr == `COMMAND_ADDR;
    wire [3:0]   cmd      = reg_req_i.wdata[7:4];
    wire         cmd_start   = wr_cmd && cmd == `CMD_START_CT;
    wire         cmd_stop    = wr_cmd && cmd == `CMD_STOP_CT;
    wire         cmd_set_rts = wr_cmd && cmd == `CMD_SET_RTS;
    wire         cmd_clr_rts = wr_cmd && cmd == `CMD_CLR_RTS;
    wire         cmd_clr_mpi = wr_cmd && cmd == `CMD_CLR_MPI_CHG;
    wire         cmd_clr_brk = wr_cmd && cmd == `CMD_CLR_BRK_CHG;
    wire         rd_status   = reg_req_i.rd && reg_req_i.addr == `INT_STATUS_ADDR;

    wire [2:0]   ct_mode  = auxiliary_control_q[`CT_MODE_MSB:`CT_MODE_LSB];
    wire [2:0]   out_sel  = auxiliary_control_q[`OUT_SEL_MSB:`OUT_SEL_LSB];
    wire         timer_mode = ct_mode[2];
    wire         powered  = auxiliary_control_q[`PWR_SEL_BIT];

    // synchronised pins and their edges
    wire         mpi_now  = mpi_sync_q[1];
    wire         mpi_rise = mpi_now && !mpi_last_q;
    wire         mpi_edge = mpi_now != mpi_last_q;
    wire         osc_rise = osc_sync_q[1] && !osc_last_q && powered;

    // clock source table for counter and timer
    logic        ct_tick;
    always_comb begin
        unique case (ct_mode)
            3'h0, 3'h4: ct_tick = mpi_rise;
            3'h1, 3'h5: ct_tick = mpi_div_tick_q;
            3'h2:       ct_tick = chan_i.tx_clk_1x;
            3'h6:       ct_tick = osc_rise;
            3'h3, 3'h7: ct_tick = osc_div_tick_q;
        endcase
    end

    wire [15:0]  count_regs = {count_upper_byte_q, count_lower_byte_q};
    wire         at_one     = ct_value_q == 16'h0001;

    // counter/timer engine
    always_comb begin
        ct_state_d = ct_state_q;
        ct_value_d = ct_value_q;
        ct_start_d = ct_start_q;
        ct_wave_d  = ct_wave_q;
        ct_half_d  = ct_half_q;
        ct_term_d  = 1'b0;
        if (cmd_start && (timer_mode || ct_state_q == ct_unit_pkg::CT_IDLE)) begin
            ct_start_d = count_regs;
            ct_value_d = count_regs;
            ct_state_d = ct_unit_pkg::CT_RUN;
            ct_wave_d  = 1'b1;
            ct_half_d  = 1'b0;
        end else if (cmd_stop && !timer_mode) begin
            ct_state_d = ct_unit_pkg::CT_IDLE;
            ct_wave_d  = 1'b1;
        end else if (ct_state_q == ct_unit_pkg::CT_RUN && ct_tick) begin
            if (timer_mode) begin
                if (at_one) begin
                    ct_value_d = count_regs;
                    ct_wave_d  = !ct_wave_q;
                    ct_half_d  = !ct_half_q;
                    ct_term_d  = ct_half_q;
                end else begin
                    ct_value_d = ct_value_q - 16'h0001;
                end
            end else begin
                ct_value_d = ct_value_q - 16'h0001;
                if (at_one) begin
                    ct_term_d = 1'b1;
                    ct_wave_d = 1'b0;
                end
            end
        end
    end

    // status bits: set wins over clear
    wire         mpi_chg_d  = mpi_edge || (mpi_chg_q && !cmd_clr_mpi);
    wire         brk_chg_d  = chan_i.break_change || (brk_chg_q && !cmd_clr_brk);
    wire         ct_ready_d = ct_term_q || (ct_ready_q && !cmd_stop);
    wire         rx_set     = mode_ctrl_q[`MODE_FFULL_BIT] ?
                              (chan_i.rx_char_in && chan_i.rx_fifo_full) :
                              chan_i.rx_char_in;
    wire         rx_clr     = mode_ctrl_q[`MODE_FFULL_BIT] ?
                              (chan_i.rx_fifo_read && !chan_i.rx_shift_full) :
                              chan_i.rx_fifo_read;
    wire         rx_again   = !mode_ctrl_q[`MODE_FFULL_BIT] && chan_i.rx_fifo_nonempty;
    wire         rx_flag_d  = rx_set || (rx_flag_q && !rx_clr) || (rx_clr && rx_again);

    wire [7:0]   status = {mpi_chg_q, mpi_level_q, 1'b0, ct_ready_q, brk_chg_q,
                           rx_flag_q, chan_i.tx_empty, chan_i.tx_ready};
    wire         int_any = |(status & interrupt_mask_q);

    // multipurpose output selector
    wire         rts_auto = (mode_ctrl_q[`MODE_TX_RTS_BIT] && chan_i.tx_done) ||
                            (mode_ctrl_q[`MODE_RX_RTS_BIT] && chan_i.rx_fifo_full &&
                             chan_i.rx_shift_full);
    logic        mpo_d;
    always_comb begin
        unique case (out_sel)
            3'h0: mpo_d = !rts_reg_q;
            3'h1: mpo_d = ct_wave_q;
            3'h2: mpo_d = chan_i.tx_clk_1x;
            3'h3: mpo_d = chan_i.tx_clk_16x;
            3'h4: mpo_d = chan_i.rx_clk_1x;
            3'h5: mpo_d = chan_i.rx_clk_16x;
            3'h6: mpo_d = !chan_i.tx_ready;
            3'h7: mpo_d = !rx_flag_q;
        endcase
    end

    wire         rts_reg_d = cmd_set_rts ? 1'b1 :
                             (cmd_clr_rts || rts_auto) ? 1'b0 : rts_reg_q;

    // register read mux; write-only registers read as zero
    wire [7:0]   rdata_d = rd_status ? {status[7], mpi_now, status[5:0]} : 8'h00;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mpi_sync_q <= 2'b00;
            osc_sync_q <= 2'b00;
            mpi_last_q <= 1'b0;
            osc_last_q <= 1'b0;
        end else begin
            mpi_sync_q <= {mpi_sync_q[0], multipurpose_input_pin_i};
            osc_sync_q <= {osc_sync_q[0], osc_clk_i};
            mpi_last_q <= mpi_sync_q[1];
            osc_last_q <= osc_sync_q[1];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mpi_div_q      <= 4'h0;
            osc_div_q      <= 4'h0;
            mpi_div_tick_q <= 1'b0;
            osc_div_tick_q <= 1'b0;
        end else begin
            mpi_div_tick_q <= mpi_rise && mpi_div_q == `PRESCALE_DIV;
            osc_div_tick_q <= osc_rise && osc_div_q == `PRESCALE_DIV;
            if (mpi_rise) mpi_div_q <= mpi_div_q + 4'h1;
            if (osc_rise) osc_div_q <= osc_div_q + 4'h1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            auxiliary_control_q <= `AUX_CTRL_RESET;
            interrupt_mask_q    <= `MASK_RESET;
            count_upper_byte_q  <= 8'(`COUNT_RESET >> 8);
            count_lower_byte_q  <= 8'(`COUNT_RESET);
            mode_ctrl_q         <= `MODE_CTRL_RESET;
        end else begin
            if (wr_aux)   auxiliary_control_q <= reg_req_i.wdata;
            if (wr_mask)  interrupt_mask_q    <= reg_req_i.wdata;
            if (wr_upper) count_upper_byte_q  <= reg_req_i.wdata;
            if (wr_lower) count_lower_byte_q  <= reg_req_i.wdata;
            if (wr_mode)  mode_ctrl_q         <= reg_req_i.wdata;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ct_state_q <= ct_unit_pkg::CT_IDLE;
            ct_value_q <= `COUNT_RESET;
            ct_start_q <= `COUNT_RESET;
            ct_wave_q  <= 1'b1;
            ct_half_q  <= 1'b0;
            ct_term_q  <= 1'b0;
        end else begin
            ct_state_q <= ct_state_d;
            ct_value_q <= ct_value_d;
            ct_start_q <= ct_start_d;
            ct_wave_q  <= ct_wave_d;
            ct_half_q  <= ct_half_d;
            ct_term_q  <= ct_term_d;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mpi_chg_q   <= 1'b0;
            brk_chg_q   <= 1'b0;
            ct_ready_q  <= 1'b0;
            rx_flag_q   <= 1'b0;
            mpi_level_q <= 1'b0;
        end else begin
            mpi_chg_q  <= mpi_chg_d;
            brk_chg_q  <= brk_chg_d;
            ct_ready_q <= ct_ready_d;
            rx_flag_q  <= rx_flag_d;
            if (rd_status) mpi_level_q <= mpi_now;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rts_reg_q <= 1'b0;
            mpo_q     <= 1'b1;
            intr_n_q  <= 1'b1;
            rdata_q   <= 8'h00;
        end else begin
            rts_reg_q <= rts_reg_d;
            mpo_q     <= mpo_d;
            intr_n_q  <= !int_any;
            rdata_q   <= rdata_d;
        end
    end

    assign reg_rdata_o               = rdata_q;
    assign multipurpose_output_pin_o = mpo_q;
    assign interrupt_request_n_o     = intr_n_q;
    // power-down forces oscillator pins; control bit comes from a register
    assign oscillator_input_o        = 1'b0;
    assign oscillator_input_oe_o     = !auxiliary_control_q[`PWR_SEL_BIT];
    assign oscillator_output_o       = !auxiliary_control_q[`PWR_SEL_BIT] ||
                                       rate_generator_16x_i;
    assign osc_enable_o              = auxiliary_control_q[`PWR_SEL_BIT];

endmodule : ct_unit

// File: pkg/ct_unit_regs.svh
/*
 * register indices, field positions, reset values and timing counts of the
 * counter/timer and interrupt unit. assumes a plain 8-bit register port.
 */
`ifndef CT_UNIT_REGS_SVH
`define CT_UNIT_REGS_SVH

`define AUX_CTRL_ADDR      3'h0
`define INT_STATUS_ADDR    3'h1
`define INT_MASK_ADDR      3'h2
`define CNT_UPPER_ADDR     3'h3
`define CNT_LOWER_ADDR     3'h4
`define COMMAND_ADDR       3'h5
`define CHAN_STATUS_ADDR   3'h6
`define MODE_CTRL_ADDR     3'h7

`define AUX_CTRL_RESET     8'h00
`define MASK_RESET         8'h00
`define COUNT_RESET        16'h0002
`define MODE_CTRL_RESET    8'h00

`define PWR_SEL_BIT        3
`define CT_MODE_MSB        6
`define CT_MODE_LSB        4
`define OUT_SEL_MSB        2
`define OUT_SEL_LSB        0
`define MODE_FFULL_BIT     0
`define MODE_RX_RTS_BIT    1
`define MODE_TX_RTS_BIT    2

`define ST_MPI_CHANGE      7
`define ST_MPI_LEVEL       6
`define ST_CT_READY        4
`define ST_BREAK_CHANGE    3
`define ST_RX_READY        2
`define ST_TX_EMPTY        1
`define ST_TX_READY        0

`define CMD_START_CT       4'h8
`define CMD_STOP_CT        4'h9
`define CMD_SET_RTS        4'ha
`define CMD_CLR_RTS        4'hb
`define CMD_CLR_MPI_CHG    4'hc
`define CMD_CLR_BRK_CHG    4'h5

`define PRESCALE_DIV       4'hf

`endif

// File: pkg/ct_unit_pkg.sv
/*
 * types shared by the counter/timer and interrupt unit.
 * assumes ct_unit_regs.svh holds the numbers.
 */
package ct_unit_pkg;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic tx_empty;
        logic tx_ready;
        logic rx_char_in;
        logic rx_fifo_read;
        logic rx_fifo_nonempty;
        logic rx_fifo_full;
        logic rx_shift_full;
        logic break_change;
        logic tx_done;
        logic tx_clk_1x;
        logic tx_clk_16x;
        logic rx_clk_1x;
        logic rx_clk_16x;
    } chan_in_t;

    typedef enum logic [1:0] {
        CT_IDLE,
        CT_RUN
    } ct_state_t;

endpackage : ct_unit_pkg

// File: verif/ct_unit_monitor.sv
/* checker for ct_unit: port-level relations of power select, interrupt and status.
   assumes register indices from ct_unit_regs.svh and one clock domain. */
`timescale 1ns/1ns
`include "ct_unit_regs.svh"
module ct_unit_monitor (
    input wire logic                  core_clk_i,
    input wire logic                  rst_b_i,
    input wire ct_unit_pkg::reg_req_t reg_req_i,
    input wire logic [7:0]            reg_rdata_o,
    input wire ct_unit_pkg::chan_in_t chan_i,
    input wire logic                  multipurpose_input_pin_i,
    input wire logic                  osc_clk_i,
    input wire logic                  rate_generator_16x_i,
    input wire logic                  multipurpose_output_pin_o,
    input wire logic                  interrupt_request_n_o,
    input wire logic                  oscillator_input_o,
    input wire logic                  oscillator_input_oe_o,
    input wire logic                  oscillator_output_o,
    input wire logic                  osc_enable_o
);
    logic [7:0] mask_q;
    logic [7:0] aux_q;
    logic [1:0] tx_q;
    logic       mpi_q;
    logic [2:0] tx_hold_q;
    logic [2:0] mpi_hold_q;
    wire        wr_aux = reg_req_i.wr && reg_req_i.addr == `AUX_CTRL_ADDR;
    wire        wr_mask = reg_req_i.wr && reg_req_i.addr == `INT_MASK_ADDR;
    wire        rd_st = reg_req_i.rd && reg_req_i.addr == `INT_STATUS_ADDR;
    wire [1:0]  tx_now = {chan_i.tx_empty, chan_i.tx_ready};
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask_q <= 8'h00;
            aux_q <= 8'h00;
            tx_q <= 2'h0;
            mpi_q <= 1'b0;
            tx_hold_q <= 3'h0;
            mpi_hold_q <= 3'h0;
        end else begin
            if (wr_mask) mask_q <= reg_req_i.wdata;
            if (wr_aux) aux_q <= reg_req_i.wdata;
            tx_q <= tx_now;
            mpi_q <= multipurpose_input_pin_i;
            tx_hold_q <= (tx_now != tx_q) ? 3'h0 : tx_hold_q + {2'h0, tx_hold_q != 3'h7};
            mpi_hold_q <= (multipurpose_input_pin_i != mpi_q) ? 3'h0
                        : mpi_hold_q + {2'h0, mpi_hold_q != 3'h7};
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_stop_cmd;
        reg_req_i.wr && reg_req_i.addr == `COMMAND_ADDR && reg_req_i.wdata[7:4] == `CMD_STOP_CT;
    endsequence
    sequence s_tx_steady;
        tx_hold_q >= 3'h3 && tx_now == tx_q;
    endsequence
    property p_pd_pins;
        !osc_enable_o |-> oscillator_input_oe_o && !oscillator_input_o && oscillator_output_o;
    endproperty
    a_pd_pins: assert property (p_pd_pins) else $error("power-down pin levels wrong");
    property p_osc_out;
        osc_enable_o |-> oscillator_output_o == rate_generator_16x_i;
    endproperty
    a_osc_out: assert property (p_osc_out) else $error("rate clock not passed out");
    property p_pwr_sel;
        wr_aux |=> osc_enable_o == $past(reg_req_i.wdata[`PWR_SEL_BIT]);
    endproperty
    a_pwr_sel: assert property (p_pwr_sel) else $error("power select not taken");
    property p_pwr_hold;
        !wr_aux |=> $stable(osc_enable_o);
    endproperty
    a_pwr_hold: assert property (p_pwr_hold) else $error("power select moved alone");
    property p_mask_off;
        mask_q == 8'h00 && $stable(mask_q) |-> interrupt_request_n_o;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("interrupt with mask clear");
    property p_transmit_holding_free_int;
        (mask_q == 8'h01 && $stable(mask_q)) ##0 s_tx_steady
            |-> interrupt_request_n_o == !chan_i.tx_ready;
    endproperty
    a_transmit_holding_free_int: assert property (p_transmit_holding_free_int) else $error("tx ready interrupt wrong");
    property p_st_tx;
        rd_st ##0 s_tx_steady |=> reg_rdata_o[1:0] == $past(tx_now);
    endproperty
    a_st_tx: assert property (p_st_tx) else $error("status tx bits wrong");
    property p_st_mpi;
        rd_st && mpi_hold_q >= 3'h4 && multipurpose_input_pin_i == mpi_q
            |=> reg_rdata_o[6] == $past(multipurpose_input_pin_i);
    endproperty
    a_st_mpi: assert property (p_st_mpi) else $error("status input level wrong");
    property p_rst_out;
        $rose(rst_b_i) |-> interrupt_request_n_o && multipurpose_output_pin_o;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
    property p_stop_out;
        s_stop_cmd ##0 (!aux_q[6] && aux_q[2:0] == 3'h1) |-> ##[1:2] multipurpose_output_pin_o;
    endproperty
    a_stop_out: assert property (p_stop_out) else $error("stop left output low");
endmodule : ct_unit_monitor

bind ct_unit ct_unit_monitor mon_u (.core_clk_i, .rst_b_i, .reg_req_i, .reg_rdata_o, .chan_i,
    .multipurpose_input_pin_i, .osc_clk_i, .rate_generator_16x_i, .multipurpose_output_pin_o,
    .interrupt_request_n_o, .oscillator_input_o, .oscillator_input_oe_o, .oscillator_output_o,
    .osc_enable_o);

// File: verif/host_model.sv
/* host cpu model driving the register port with one-cycle strobes.
   assumes read data stand in the cycle after the read strobe. */
`timescale 1ns/1ns
`include "ct_unit_regs.svh"
module host_model (
    input  wire logic             core_clk_i,
    input  wire logic [7:0]       rdata_i,
    output ct_unit_pkg::reg_req_t req_o
);
    initial req_o = '0;
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_i);
        req_o.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        req_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_i);
        req_o.rd <= 1'b0;
        @(posedge core_clk_i);
        d = rdata_i;
    endtask : rd
    task automatic power_up();
        wr(`AUX_CTRL_ADDR, 8'h08);
    endtask : power_up
    task automatic load(input logic [15:0] n);
        wr(`CNT_UPPER_ADDR, n[15:8]);
        wr(`CNT_LOWER_ADDR, (n < 16'h0002) ? 8'h02 : n[7:0]);
    endtask : load
    task automatic cmd(input logic [3:0] c);
        wr(`COMMAND_ADDR, {c, 4'h0});
    endtask : cmd
endmodule : host_model

// File: verif/test_ct_unit.sv
/* self-checking bench of ct_unit: mpo selector, status, timer and counter.
   assumes host_model on the register port and the bound checker. */
`timescale 1ns/1ns
`include "ct_unit_regs.svh"
module test_ct_unit;
    localparam int OSC_CYC = 8;
    logic core_clk_i = 1'b0, rst_b_i = 1'b0, multipurpose_input_pin_i = 1'b0, osc_clk_i = 1'b0;
    ct_unit_pkg::reg_req_t reg_req_i;
    ct_unit_pkg::chan_in_t chan_i = '0;
    logic [7:0]  reg_rdata_o;
    logic        multipurpose_output_pin, irq_n, osc_en;
    logic [31:0] rng = 32'h0000005a;
    int          fails = 0, n_tests = 0, cyc = 0, t_edge = 0;
    always #2 core_clk_i = ~core_clk_i;
    always #16 osc_clk_i = ~osc_clk_i;
    always @(posedge core_clk_i) cyc <= cyc + 1;
    ct_unit dut_u (.core_clk_i, .rst_b_i, .reg_req_i, .reg_rdata_o, .chan_i,
        .multipurpose_input_pin_i, .osc_clk_i, .rate_generator_16x_i(osc_clk_i),
        .multipurpose_output_pin_o(multipurpose_output_pin), .interrupt_request_n_o(irq_n), .oscillator_input_o(),
        .oscillator_input_oe_o(), .oscillator_output_o(), .osc_enable_o(osc_en));
    host_model host_u (.core_clk_i, .rdata_i(reg_rdata_o), .req_o(reg_req_i));
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs
    function automatic int half(input int n);
        return n * OSC_CYC;
    endfunction : half
    function automatic logic exp_mpo(input int c, input ct_unit_pkg::chan_in_t ch);
        case (c)
            2: return ch.tx_clk_1x;
            3: return ch.tx_clk_16x;
            4: return ch.rx_clk_1x;
            5: return ch.rx_clk_16x;
            default: return !ch.tx_ready;
        endcase
    endfunction : exp_mpo
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim
    task automatic settle();
        repeat (4) @(posedge core_clk_i);
    endtask : settle
    task automatic drive(input logic [12:0] v);
        @(posedge core_clk_i);
        chan_i <= v;
    endtask : drive
    task automatic ticks(input int k);
        repeat (k) begin
            drive(13'h0008);
            drive(13'h0000);
        end
    endtask : ticks
    // cycles since the previous output edge
    task automatic gap(output int k);
        logic v;
        int   w;
        v = multipurpose_output_pin;
        w = 0;
        while (multipurpose_output_pin === v && w < 4000) begin
            @(posedge core_clk_i);
            w++;
        end
        k = cyc - t_edge;
        t_edge = cyc;
    endtask : gap
    initial begin
        #80000;
        fails++;
        end_sim();
    end
    initial begin
        int n, m, k, c;
        logic [7:0] st;
        repeat (8) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        host_u.rd(`INT_STATUS_ADDR, st);
        chk(st, 8'h00);
        chk(osc_en, 1'b0);
        host_u.power_up();
        settle();
        chk(osc_en, 1'b1);
        host_u.wr(`AUX_CTRL_ADDR, 8'h00);
        settle();
        chk(osc_en, 1'b0);
        $display("power select test done");
        host_u.wr(`INT_MASK_ADDR, 8'h01);
        host_u.wr(`AUX_CTRL_ADDR, 8'h08);
        host_u.cmd(`CMD_SET_RTS);
        settle();
        chk(multipurpose_output_pin, 1'b0);
        host_u.cmd(`CMD_CLR_RTS);
        settle();
        chk(multipurpose_output_pin, 1'b1);
        for (c = 2; c < 7; c++) begin
            host_u.wr(`AUX_CTRL_ADDR, 8'h08 | 8'(c));
            repeat (4) begin
                k = xs();
                drive({k[5:4], 7'h00, k[3:0]});
                settle();
                chk(multipurpose_output_pin, exp_mpo(c, chan_i));
            end
        end
        drive(13'h0000);
        host_u.wr(`AUX_CTRL_ADDR, 8'h0f);
        drive(13'h0500);
        drive(13'h0100);
        settle();
        chk(multipurpose_output_pin, 1'b0);
        drive(13'h0200);
        drive(13'h0000);
        settle();
        chk(multipurpose_output_pin, 1'b1);
        host_u.wr(`MODE_CTRL_ADDR, 8'h01);
        drive(13'h0400);
        drive(13'h0000);
        settle();
        chk(multipurpose_output_pin, 1'b1);
        drive(13'h0480);
        drive(13'h02c0);
        settle();
        chk(multipurpose_output_pin, 1'b0);
        drive(13'h0200);
        drive(13'h0000);
        settle();
        chk(multipurpose_output_pin, 1'b1);
        host_u.wr(`MODE_CTRL_ADDR, 8'h04);
        host_u.wr(`AUX_CTRL_ADDR, 8'h08);
        host_u.cmd(`CMD_SET_RTS);
        settle();
        chk(multipurpose_output_pin, 1'b0);
        drive(13'h0010);
        drive(13'h0000);
        settle();
        chk(multipurpose_output_pin, 1'b1);
        $display("output select test done");
        host_u.wr(`INT_MASK_ADDR, 8'h88);
        @(posedge core_clk_i) multipurpose_input_pin_i <= 1'b1;
        repeat (8) @(posedge core_clk_i);
        host_u.rd(`INT_STATUS_ADDR, st);
        chk(st[7:6], 2'b11);
        chk(irq_n, 1'b0);
        host_u.cmd(`CMD_CLR_MPI_CHG);
        host_u.rd(`INT_STATUS_ADDR, st);
        chk(st[7], 1'b0);
        drive(13'h0020);
        drive(13'h0000);
        host_u.rd(`INT_STATUS_ADDR, st);
        chk(st[3], 1'b1);
        host_u.cmd(`CMD_CLR_BRK_CHG);
        host_u.rd(`INT_STATUS_ADDR, st);
        chk(st[3], 1'b0);
        settle();
        chk(irq_n, 1'b1);
        $display("status test done");
        n = 2 + xs() % 6;
        m = 2 + xs() % 6;
        host_u.wr(`INT_MASK_ADDR, 8'h00);
        host_u.load(n[15:0]);
        host_u.wr(`AUX_CTRL_ADDR, 8'h69);
        host_u.cmd(`CMD_START_CT);
        gap(k);
        gap(k);
        chk(k, half(n));
        host_u.load(m[15:0]);
        gap(k);
        chk(k, half(n));
        gap(k);
        chk(k, half(m));
        host_u.rd(`INT_STATUS_ADDR, st);
        chk(st[4], 1'b1);
        gap(k);
        host_u.cmd(`CMD_STOP_CT);
        host_u.rd(`INT_STATUS_ADDR, st);
        chk(st[4], 1'b0);
        gap(k);
        gap(k);
        chk(k, half(m));
        $display("timer test done");
        host_u.wr(`AUX_CTRL_ADDR, 8'h29);
        host_u.cmd(`CMD_STOP_CT);
        host_u.wr(`INT_MASK_ADDR, 8'h10);
        host_u.load(n[15:0]);
        for (c = 0; c < 2; c++) begin
            host_u.cmd(`CMD_START_CT);
            host_u.load(m[15:0]);
            ticks((c == 0 ? n : m) - 1);
            settle();
            chk(multipurpose_output_pin, 1'b1);
            ticks(1);
            settle();
            chk(multipurpose_output_pin, 1'b0);
            chk(irq_n, 1'b0);
            host_u.cmd(`CMD_STOP_CT);
            settle();
            chk({multipurpose_output_pin, irq_n}, 2'b11);
        end
        host_u.wr(`AUX_CTRL_ADDR, 8'h09);
        host_u.cmd(`CMD_START_CT);
        for (c = 0; c < 2 * m; c++) begin
            @(posedge core_clk_i) multipurpose_input_pin_i <= !multipurpose_input_pin_i;
            repeat (6) @(posedge core_clk_i);
            if (c >= 2 * m - 3) chk(multipurpose_output_pin, c == 2 * m - 1 ? 1'b0 : 1'b1);
        end
        $display("counter test done");
        end_sim();
    end
endmodule : test_ct_unit
